// file: src/rssa_pkg.sv
// Purpose: shared constants and types of the rotate, subtract and swap slice
// Assumes: 32-bit AXI4-Lite register access, 8-bit datapath
// Notes: one localparam per offset, field position, reset value and width
package rssa_pkg;
    // ==========================================================
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    localparam int WDOG_CNT_W = 8;
    localparam int WDOG_PRE_W = 8;
    // ==========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_ACC = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_FADDR = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_FDATA = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_WDOG = 8'h14;
    // ==========================================================
    // field positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PWRDN = 3;
    localparam int ST_TMOUT = 4;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST = 3;
    localparam int CMD_LIT_LSB = 8;
    localparam int CMD_FA_LSB = 16;
    localparam int WDOG_PRE_LSB = 8;
    // ==========================================================
    // reset values and responses
    localparam logic [4:0] STATUS_RST = 5'h18;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // operations
    typedef enum logic [2:0] {
        OP_NOP = 3'b000,
        OP_ROT = 3'b001,
        OP_LIT = 3'b010,
        OP_FSUB = 3'b011,
        OP_FSUBB = 3'b100,
        OP_SWAP = 3'b101,
        OP_SLEEP = 3'b110
    } rssa_op_type;
endpackage : rssa_pkg

// file: src/rssa_ifs.sv
// Purpose: carriers between the core and its alu and watchdog
// Assumes: rssa_pkg compiled first
// Notes: no clocking blocks
`timescale 1ns/1ps
interface rssa_alu_if;
    import rssa_pkg::*;
    rssa_op_type op;
    logic dest;
    logic [7:0] fsrc;
    logic [7:0] acc;
    logic [7:0] lit;
    logic cin;
    logic [7:0] result;
    logic c;
    logic dc;
    logic z;
    logic upd_c;
    logic upd_dcz;
    logic to_acc;
    logic to_file;
    modport core(output op, dest, fsrc, acc, lit, cin,
        input result, c, dc, z, upd_c, upd_dcz, to_acc, to_file);
    modport alu(input op, dest, fsrc, acc, lit, cin,
        output result, c, dc, z, upd_c, upd_dcz, to_acc, to_file);
endinterface : rssa_alu_if

interface rssa_wdog_if;
    import rssa_pkg::*;
    logic clr;
    logic [WDOG_CNT_W-1:0] count;
    logic [WDOG_PRE_W-1:0] presc;
    modport core(output clr, input count, presc);
    modport counter(input clr, output count, presc);
endinterface : rssa_wdog_if

// file: src/rssa_alu.sv
// Purpose: combinational result and flag logic of the slice
// Assumes: operands stable for the executing cycle
// Notes: borrow is the inverted carry
`timescale 1ns/1ps
module rssa_alu (
    rssa_alu_if.alu bus
);
    import rssa_pkg::*;
    // ==========================================================
    // subtract as add of complement
    function automatic logic [8:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        sub8 = {1'b0, a} + {1'b0, ~b} + {8'h00, ci};
    endfunction : sub8
    function automatic logic [4:0] sub4(input logic [3:0] a, input logic [3:0] b, input logic ci);
        sub4 = {1'b0, a} + {1'b0, ~b} + {4'h0, ci};
    endfunction : sub4

    wire is_lit = (bus.op == OP_LIT);
    wire [7:0] minuend = is_lit ? bus.lit : bus.fsrc;
    wire sub_ci = (bus.op == OP_FSUBB) ? bus.cin : 1'b1; // [RQ10]
    wire [8:0] diff = sub8(minuend, bus.acc, sub_ci); // [RQ6] [RQ8] [RQ10]
    wire [4:0] half = sub4(minuend[3:0], bus.acc[3:0], sub_ci); // [RQ7] [RQ9]
    logic writes;

    // ==========================================================
    // operation select
    always_comb begin
        bus.result = 8'h00;
        bus.c = bus.cin;
        bus.dc = 1'b0;
        bus.z = 1'b0;
        bus.upd_c = 1'b0;
        bus.upd_dcz = 1'b0;
        writes = 1'b0;
        unique case (bus.op)
            OP_ROT: begin
                bus.result = {bus.cin, bus.fsrc[7:1]}; // [RQ1]
                bus.c = bus.fsrc[0]; // [RQ1]
                bus.upd_c = 1'b1;
                writes = 1'b1;
            end
            OP_LIT, OP_FSUB, OP_FSUBB: begin
                bus.result = diff[7:0];
                bus.c = diff[8]; // [RQ7] [RQ9]
                bus.dc = half[4]; // [RQ7] [RQ9]
                bus.z = (diff[7:0] == 8'h00); // [RQ12]
                bus.upd_c = 1'b1;
                bus.upd_dcz = 1'b1;
                writes = 1'b1;
            end
            OP_SWAP: begin
                bus.result = {bus.fsrc[3:0], bus.fsrc[7:4]}; // [RQ11]
                writes = 1'b1;
            end
            OP_NOP, OP_SLEEP: begin
                writes = 1'b0;
            end
            default: begin
                writes = 1'b0;
            end
        endcase
    end

    assign bus.to_acc = writes && (is_lit || !bus.dest); // [RQ2]
    assign bus.to_file = writes && !is_lit && bus.dest; // [RQ2]
endmodule : rssa_alu

// file: src/rssa_watchdog.sv
// Purpose: watchdog counter with prescaler, cleared on sleep
// Assumes: clr is a one-cycle pulse
// Notes: counter steps when the prescaler wraps
`timescale 1ns/1ps
module rssa_watchdog (
    input wire logic aclk,
    input wire logic aresetn,
    rssa_wdog_if.counter wd
);
    import rssa_pkg::*;
    logic [WDOG_CNT_W-1:0] count_q;
    logic [WDOG_PRE_W-1:0] presc_q;
    wire wrap = &presc_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || wd.clr) begin // [RQ3]
            count_q <= '0;
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
            count_q <= wrap ? count_q + 1'b1 : count_q;
        end
    end

    assign wd.count = count_q;
    assign wd.presc = presc_q;
endmodule : rssa_watchdog

// file: src/rssa_top.sv
// Purpose: rotate, subtract, swap and sleep slice with AXI4-Lite registers
// Assumes: one outstanding write and one outstanding read
// Notes: a command write executes one cycle after it is taken
// Contract
// [RQ1] rotate right through carry, only carry changes
// [RQ2] destination bit zero to accumulator, else file; the literal subtract writes the accumulator whatever the bit
// [RQ3] sleep clears watchdog counter and prescaler
// [RQ4] sleep clears powerdown status, only status changes
// [RQ5] sleep sets timeout status
// [RQ6] literal minus accumulator into accumulator, flags updated
// [RQ7] literal subtract carry and half carry meaning
// [RQ8] file minus accumulator, result per destination
// [RQ9] file subtract carry and half carry meaning
// [RQ10] borrow subtract removes inverted carry too
// [RQ11] nibble exchange per destination, flags kept
// [RQ12] subtraction zero flag follows eight-bit result
`timescale 1ns/1ps
module rssa_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [rssa_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [rssa_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [rssa_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [rssa_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import rssa_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    function automatic logic map_hit(input logic [ADDR_W-1:0] a);
        map_hit = (a == ADDR_ACC) || (a == ADDR_STATUS) || (a == ADDR_CMD)
            || (a == ADDR_FADDR) || (a == ADDR_FDATA) || (a == ADDR_WDOG);
    endfunction : map_hit

    function automatic logic [31:0] view(input logic [ADDR_W-1:0] a, input logic [31:0] acc_w,
        input logic [31:0] st_w, input logic [31:0] cmd_w, input logic [31:0] fa_w,
        input logic [31:0] fd_w, input logic [31:0] wd_w);
        view = (a == ADDR_ACC) ? acc_w :
            (a == ADDR_STATUS) ? st_w :
            (a == ADDR_CMD) ? cmd_w :
            (a == ADDR_FADDR) ? fa_w :
            (a == ADDR_FDATA) ? fd_w :
            (a == ADDR_WDOG) ? wd_w : 32'h0000_0000;
    endfunction : view

    // ==========================================================
    // state
    logic aw_full_q;
    logic w_full_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] acc_q;
    logic c_q;
    logic dc_q;
    logic z_q;
    logic pwrdn_q;
    logic tmout_q;
    rssa_op_type op_q;
    logic dest_q;
    logic [7:0] lit_q;
    logic [FADDR_W-1:0] fa_q;
    logic go_q;
    logic [FADDR_W-1:0] win_q;
    logic [7:0] file_mem [0:FILE_DEPTH-1];

    rssa_alu_if alu_bus ();
    rssa_wdog_if wd_bus ();

    // ==========================================================
    // write channel
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire have_aw = aw_full_q || aw_take;
    wire have_w = w_full_q || w_take;
    wire wr_fire = have_aw && have_w;
    wire [ADDR_W-1:0] wr_addr = aw_full_q ? awaddr_q : awaddr;
    wire [ADDR_W-1:0] wr_word = {wr_addr[ADDR_W-1:2], 2'b00};
    wire [31:0] wr_data = w_full_q ? wdata_q : wdata;
    wire [3:0] wr_strb = w_full_q ? wstrb_q : wstrb;
    wire wr_hit = map_hit(wr_word);

    assign awready = !aw_full_q && !bvalid_q;
    assign wready = !w_full_q && !bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awaddr_q <= '0;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end else if (aw_take) begin
            aw_full_q <= 1'b1;
            awaddr_q <= awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end else if (w_take) begin
            w_full_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // register views
    wire [31:0] acc_w = {24'h000000, acc_q};
    wire [4:0] status = {tmout_q, pwrdn_q, z_q, dc_q, c_q};
    wire [31:0] st_w = {27'h0000000, status};
    wire [31:0] cmd_w = {9'h000, fa_q, lit_q, 4'h0, dest_q, op_q};
    wire [31:0] fa_w = {25'h0000000, win_q};
    wire [31:0] fd_w = {24'h000000, file_mem[win_q]};
    wire [31:0] wd_w = {16'h0000, wd_bus.presc, wd_bus.count};
    wire [31:0] wr_old = view(wr_word, acc_w, st_w, cmd_w, fa_w, fd_w, wd_w);
    wire [31:0] wr_val = merge(wr_old, wr_data, wr_strb);

    wire wr_acc = wr_fire && (wr_word == ADDR_ACC);
    wire wr_st = wr_fire && (wr_word == ADDR_STATUS);
    wire wr_cmd = wr_fire && (wr_word == ADDR_CMD);
    wire wr_fa = wr_fire && (wr_word == ADDR_FADDR);
    wire wr_fd = wr_fire && (wr_word == ADDR_FDATA);

    // ==========================================================
    // read channel
    wire ar_take = arvalid && arready;
    wire [ADDR_W-1:0] rd_word = {araddr[ADDR_W-1:2], 2'b00};
    wire [31:0] rd_val = view(rd_word, acc_w, st_w, cmd_w, fa_w, fd_w, wd_w);

    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= map_hit(rd_word) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // execution
    wire is_sleep = go_q && (op_q == OP_SLEEP);
    wire exec_acc = go_q && alu_bus.to_acc; // [RQ2]
    wire exec_file = go_q && alu_bus.to_file; // [RQ2]
    wire exec_c = go_q && alu_bus.upd_c;
    wire exec_dcz = go_q && alu_bus.upd_dcz;

    assign alu_bus.op = op_q;
    assign alu_bus.dest = dest_q;
    assign alu_bus.fsrc = file_mem[fa_q];
    assign alu_bus.acc = acc_q;
    assign alu_bus.lit = lit_q;
    assign alu_bus.cin = c_q;
    assign wd_bus.clr = is_sleep; // [RQ3]

    rssa_alu u_alu (
        .bus(alu_bus.alu)
    );

    rssa_watchdog u_wdog (
        .aclk(aclk),
        .aresetn(aresetn),
        .wd(wd_bus.counter)
    );

    wire [7:0] acc_d = exec_acc ? alu_bus.result : (wr_acc ? wr_val[7:0] : acc_q); // [RQ6]
    wire c_d = exec_c ? alu_bus.c : (wr_st ? wr_val[ST_C] : c_q); // [RQ1]
    wire dc_d = exec_dcz ? alu_bus.dc : (wr_st ? wr_val[ST_DC] : dc_q);
    wire z_d = exec_dcz ? alu_bus.z : (wr_st ? wr_val[ST_Z] : z_q); // [RQ12]
    wire pwrdn_d = is_sleep ? 1'b0 : (wr_st ? wr_val[ST_PWRDN] : pwrdn_q); // [RQ4]
    wire tmout_d = is_sleep ? 1'b1 : (wr_st ? wr_val[ST_TMOUT] : tmout_q); // [RQ5]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q <= ACC_RST;
            {tmout_q, pwrdn_q, z_q, dc_q, c_q} <= STATUS_RST;
        end else begin
            acc_q <= acc_d;
            c_q <= c_d;
            dc_q <= dc_d;
            z_q <= z_d;
            pwrdn_q <= pwrdn_d;
            tmout_q <= tmout_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_q <= OP_NOP;
            dest_q <= 1'b1;
            lit_q <= '0;
            fa_q <= '0;
            go_q <= 1'b0;
            win_q <= '0;
        end else begin
            go_q <= wr_cmd;
            if (wr_cmd) begin
                op_q <= rssa_op_type'(wr_val[CMD_OP_LSB +: 3]);
                dest_q <= wr_val[CMD_DEST];
                lit_q <= wr_val[CMD_LIT_LSB +: 8];
                fa_q <= wr_val[CMD_FA_LSB +: FADDR_W]; // [RQ8]
            end
            if (wr_fa) begin
                win_q <= wr_val[FADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (exec_file) begin
            file_mem[fa_q] <= alu_bus.result; // [RQ2] [RQ8] [RQ11]
        end else if (wr_fd) begin
            file_mem[win_q] <= wr_val[7:0];
        end
    end

    // ==========================================================
    // checks
    logic [7:0] src_p_q;
    logic [7:0] acc_p_q;
    logic [7:0] lit_p_q;
    logic [FADDR_W-1:0] fa_p_q;
    logic [4:0] st_p_q;

    always_ff @(posedge aclk) begin
        src_p_q <= alu_bus.fsrc;
        acc_p_q <= acc_q;
        lit_p_q <= lit_q;
        fa_p_q <= fa_q;
        st_p_q <= status;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_exec(rssa_op_type o);
        go_q && (op_q == o);
    endsequence
    sequence s_to_acc(rssa_op_type o);
        go_q && (op_q == o) && !dest_q;
    endsequence
    sequence s_to_file(rssa_op_type o);
        go_q && (op_q == o) && dest_q;
    endsequence

    a_rot_carry: assert property (s_exec(OP_ROT) |=> c_q == src_p_q[0] && status[4:1] == st_p_q[4:1]) // [RQ1]
        else $error("rotate carry wrong");
    a_rot_value: assert property (s_to_acc(OP_ROT) |=> acc_q == {st_p_q[ST_C], src_p_q[7:1]}) // [RQ1]
        else $error("rotate result wrong");
    a_rot_file: assert property (s_to_file(OP_ROT) // [RQ1]
        |=> file_mem[fa_p_q] == {st_p_q[ST_C], src_p_q[7:1]} && acc_q == acc_p_q)
        else $error("rotate write-back wrong");
    a_dest_file: assert property (s_to_file(OP_SWAP) // [RQ2]
        |=> file_mem[fa_p_q] == {src_p_q[3:0], src_p_q[7:4]} && acc_q == acc_p_q)
        else $error("file destination wrong");
    a_sleep_wdog: assert property (s_exec(OP_SLEEP) |=> wd_bus.count == 8'h00 && wd_bus.presc == 8'h00) // [RQ3]
        else $error("watchdog not cleared");
    a_sleep_pwrdn: assert property (s_exec(OP_SLEEP) // [RQ4]
        |=> !pwrdn_q && status[2:0] == st_p_q[2:0] && acc_q == acc_p_q)
        else $error("powerdown not cleared");
    a_sleep_tmout: assert property (s_exec(OP_SLEEP) |=> tmout_q) // [RQ5]
        else $error("timeout not set");
    a_lit_result: assert property (s_exec(OP_LIT) |=> acc_q == 8'(lit_p_q - acc_p_q)) // [RQ6]
        else $error("literal subtract result wrong");
    a_lit_flags: assert property (s_exec(OP_LIT) // [RQ7]
        |=> c_q == (acc_p_q <= lit_p_q) && dc_q == (acc_p_q[3:0] <= lit_p_q[3:0]))
        else $error("literal subtract flags wrong");
    a_fsub_result: assert property (s_to_acc(OP_FSUB) |=> acc_q == 8'(src_p_q - acc_p_q)) // [RQ8]
        else $error("file subtract result wrong");
    a_fsub_file: assert property (s_to_file(OP_FSUB) // [RQ8]
        |=> file_mem[fa_p_q] == 8'(src_p_q - acc_p_q) && acc_q == acc_p_q)
        else $error("file subtract write-back wrong");
    a_fsub_flags: assert property (s_exec(OP_FSUB) // [RQ9]
        |=> c_q == (acc_p_q <= src_p_q) && dc_q == (acc_p_q[3:0] <= src_p_q[3:0]))
        else $error("file subtract flags wrong");
    a_borrow_result: assert property (s_to_acc(OP_FSUBB) // [RQ10]
        |=> acc_q == 8'(src_p_q - acc_p_q - {7'h00, !st_p_q[ST_C]}))
        else $error("borrow subtract result wrong");
    a_borrow_flags: assert property (s_exec(OP_FSUBB) // [RQ10]
        |=> c_q == ({1'b0, acc_p_q} + {8'h00, !st_p_q[ST_C]} <= {1'b0, src_p_q}))
        else $error("borrow subtract carry wrong");
    a_swap_flags: assert property (s_to_acc(OP_SWAP) // [RQ11]
        |=> acc_q == {src_p_q[3:0], src_p_q[7:4]} && status == st_p_q)
        else $error("swap changed flags");
    a_zero_flag: assert property ((s_to_acc(OP_LIT) or s_to_acc(OP_FSUB) or s_to_acc(OP_FSUBB)) // [RQ12]
        |=> z_q == (acc_q == 8'h00))
        else $error("zero flag wrong");
    a_bresp_hold: assert property (bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped early");
    a_rdata_hold: assert property (rvalid_q && !rready |=> rvalid_q && $stable(rdata_q) && $stable(rresp_q))
        else $error("read response dropped early");
endmodule : rssa_top

// file: tb/rssa_master.sv
// Purpose: instruction issuer for the slice, an AXI4-Lite master
// Assumes: tasks are entered after a rising clock edge
// Notes: write data goes inverted once taken
`timescale 1ns/1ps
module rssa_master (
    input wire logic aclk,
    output logic [rssa_pkg::ADDR_W-1:0] awaddr,
    output logic [2:0] awprot,
    output logic awvalid,
    input wire logic awready,
    output logic [rssa_pkg::DATA_W-1:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [rssa_pkg::ADDR_W-1:0] araddr,
    output logic [2:0] arprot,
    output logic arvalid,
    input wire logic arready,
    input wire logic [rssa_pkg::DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    import rssa_pkg::*;
    assign awprot = 3'h0;
    assign arprot = 3'h0;
    // ==========================================================
    // idle levels
    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
    end
    // ==========================================================
    // write and read
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic hs;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            hs = bvalid;
            r = bresp;
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end while (!hs);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic hs;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            hs = rvalid;
            d = rdata;
            r = rresp;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
        end while (!hs);
        rready <= 1'b0;
    endtask : rd
endmodule : rssa_master

// file: tb/testbench.sv
// Purpose: self-checking bench of the rotate, subtract and swap slice
// Assumes: file array written before it is read
// Notes: reset values first, then table rows, watchdog, bus cases and a second reset
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
    import rssa_pkg::*;
    typedef struct {
        rssa_op_type op;
        logic dest;
        logic [7:0] lit;
        logic [6:0] fa;
        logic [7:0] fv, acc, st, eacc, efile, est;
    } rssa_row_type;
    logic aclk = 1'b0;
    logic aresetn;
    wire [7:0] awaddr, araddr;
    wire [2:0] awprot, arprot;
    wire [31:0] wdata, rdata;
    wire [3:0] wstrb;
    wire [1:0] bresp, rresp;
    wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] d;
    logic [1:0] r;
    rssa_row_type rows [15] = '{
        '{OP_ROT, 1'b0, 8'h00, 7'h01, 8'he6, 8'h55, 8'h1f, 8'hf3, 8'he6, 8'h1e},
        '{OP_ROT, 1'b1, 8'h00, 7'h02, 8'h01, 8'h55, 8'h18, 8'h55, 8'h00, 8'h19},
        '{OP_LIT, 1'b1, 8'h10, 7'h03, 8'haa, 8'h01, 8'h18, 8'h0f, 8'haa, 8'h19},
        '{OP_LIT, 1'b0, 8'h05, 7'h04, 8'haa, 8'h05, 8'h18, 8'h00, 8'haa, 8'h1f},
        '{OP_LIT, 1'b1, 8'h00, 7'h05, 8'haa, 8'h01, 8'h1f, 8'hff, 8'haa, 8'h18},
        '{OP_FSUB, 1'b0, 8'h00, 7'h06, 8'h20, 8'h10, 8'h18, 8'h10, 8'h20, 8'h1b},
        '{OP_FSUB, 1'b1, 8'h00, 7'h7f, 8'h7f, 8'h7f, 8'h18, 8'h7f, 8'h00, 8'h1f},
        '{OP_FSUB, 1'b1, 8'h00, 7'h00, 8'h00, 8'h01, 8'h1f, 8'h01, 8'hff, 8'h18},
        '{OP_FSUBB, 1'b1, 8'h00, 7'h08, 8'h50, 8'h20, 8'h19, 8'h20, 8'h30, 8'h1b},
        '{OP_FSUBB, 1'b0, 8'h00, 7'h09, 8'h50, 8'h20, 8'h18, 8'h2f, 8'h50, 8'h19},
        '{OP_FSUBB, 1'b1, 8'h00, 7'h0a, 8'h01, 8'h00, 8'h18, 8'h00, 8'h00, 8'h1f},
        '{OP_SWAP, 1'b1, 8'h00, 7'h0b, 8'ha5, 8'h33, 8'h1b, 8'h33, 8'h5a, 8'h1b},
        '{OP_SWAP, 1'b0, 8'h00, 7'h0c, 8'h3c, 8'h33, 8'h04, 8'hc3, 8'h3c, 8'h04},
        '{OP_SLEEP, 1'b1, 8'h00, 7'h0d, 8'h34, 8'h12, 8'h0f, 8'h12, 8'h34, 8'h17},
        '{OP_NOP, 1'b1, 8'h00, 7'h0e, 8'h34, 8'h12, 8'h0a, 8'h12, 8'h34, 8'h0a}
    };

    rssa_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    rssa_master m_u (.aclk(aclk), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // ==========================================================
    // helpers
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] rs;
        m_u.wr(a, v, 4'hf, rs);
    endtask : wreg

    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] rs;
        m_u.rd(a, v, rs);
        `CHK(v, e)
    endtask : rreg

    task automatic end_sim();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // clock, watchdog
    always #2 aclk = ~aclk;

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        end_sim();
    end

    // ==========================================================
    // tests
    initial begin
        aresetn = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rreg(ADDR_STATUS, {27'h0, STATUS_RST});
        rreg(ADDR_ACC, 32'h0);
        for (int i = 0; i < 15; i++) begin
            wreg(ADDR_ACC, {24'h0, rows[i].acc});
            wreg(ADDR_STATUS, {24'h0, rows[i].st});
            wreg(ADDR_FADDR, {25'h0, rows[i].fa});
            wreg(ADDR_FDATA, {24'h0, rows[i].fv});
            wreg(ADDR_CMD, {9'h0, rows[i].fa, rows[i].lit, 4'h0, rows[i].dest, rows[i].op});
            rreg(ADDR_ACC, {24'h0, rows[i].eacc});
            rreg(ADDR_STATUS, {24'h0, rows[i].est});
            rreg(ADDR_FDATA, {24'h0, rows[i].efile});
        end
        // watchdog running, then cleared by sleep
        repeat (260) @(posedge aclk);
        m_u.rd(ADDR_WDOG, d, r);
        `CHK(d[7:0] != 8'h00, 1'b1)
        wreg(ADDR_CMD, {29'h0, OP_SLEEP});
        m_u.rd(ADDR_WDOG, d, r);
        `CHK(d[7:0], 8'h00)
        `CHK(d[15:8] < 8'h10, 1'b1)
        // byte lane outside the accumulator leaves it alone
        wreg(ADDR_ACC, 32'h0000005a);
        m_u.wr(ADDR_ACC, 32'h0000a500, 4'h2, r);
        rreg(ADDR_ACC, 32'h0000005a);
        // unmapped place and read-only watchdog
        m_u.wr(8'h40, 32'h1, 4'hf, r);
        `CHK(r, RESP_SLVERR)
        m_u.rd(8'h40, d, r);
        `CHK(r, RESP_SLVERR)
        `CHK(d, 32'h0)
        m_u.wr(ADDR_WDOG, 32'hffff, 4'hf, r);
        `CHK(r, RESP_OKAY)
        // undefined operation code changes nothing
        wreg(ADDR_CMD, 32'h0000000f);
        rreg(ADDR_ACC, 32'h0000005a);
        rreg(ADDR_STATUS, 32'h00000012);
        // second reset in mid-run
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rreg(ADDR_STATUS, {27'h0, STATUS_RST});
        rreg(ADDR_ACC, 32'h0);
        end_sim();
    end
endmodule : testbench
